//--- dv/clkmux_sva.sv
// assertions on the link between the clock device and its host
`timescale 1ns/1ns
module clkmux_sva
(
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       cfg_we,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic       peri_stop_n,
  input wire logic       mgmt_mode,
  input wire logic [5:0] request_pin_enable
);
  // shadow copies of the bytes that steer the request pins
  logic [7:0] b3_q;
  logic [7:0] b4_q;
  logic [7:0] b5_q;
  logic [7:0] b6_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      b3_q <= 8'h00;
      b4_q <= 8'h00;
      b5_q <= 8'h00;
      b6_q <= 8'h00;
    end
    else if (cfg_we)
    begin
      if (cfg_addr == clkmux_pkg::PAIR_DIS_OFFSET)
        b3_q <= cfg_wdata;
      if (cfg_addr == clkmux_pkg::PAIR3_DIS_OFFSET)
        b4_q <= cfg_wdata;
      if (cfg_addr == clkmux_pkg::SEL_A_OFFSET)
        b5_q <= cfg_wdata;
      if (cfg_addr == clkmux_pkg::SEL_B_OFFSET)
        b6_q <= cfg_wdata;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence bit_low;
    !peri_stop_n [*3];
  endsequence
  sequence bit_high;
    peri_stop_n [*3];
  endsequence

  req_c_gate_a: assert property (
    request_pin_enable[0] == (b5_q[3] && b4_q[7]))
    else $error("request c enable wrong");
  req_d_gate_a: assert property (
    request_pin_enable[1] == (b5_q[1] && b4_q[7]))
    else $error("request d enable wrong");
  req_ef_gate_a: assert property (
    request_pin_enable[3:2] == {2{b6_q[6] && b3_q[3]}})
    else $error("request e f enable wrong");
  req_g_gate_a: assert property (
    request_pin_enable[4] == (b6_q[5] && b3_q[7]))
    else $error("request g enable wrong");
  req_h_gate_a: assert property (
    request_pin_enable[5] == (b6_q[4] && b3_q[7]))
    else $error("request h enable wrong");
  sel_a_read_a: assert property (
    cfg_addr == clkmux_pkg::SEL_A_OFFSET |-> cfg_rdata == b5_q)
    else $error("select byte a read wrong");
  sel_b_read_a: assert property (
    cfg_addr == clkmux_pkg::SEL_B_OFFSET |-> cfg_rdata == b6_q)
    else $error("select byte b read wrong");
  reset_clear_a: assert property (
    $rose(presetn) |-> request_pin_enable == 6'h00)
    else $error("request enables not clear after reset");
  shift_slot_a: assert property (
    mgmt_mode && $fell(peri_stop_n) |-> bit_low ##1 bit_high)
    else $error("select bit slot has wrong length");
endmodule

//--- dv/test_clock_request_pin_mux.sv
// self-checking bench joining both ends of the clock request mux
`timescale 1ns/1ns
module test_clock_request_pin_mux;
  typedef struct {logic bus; logic [32:0] e; logic [32:0] m;} note_t;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  request_n_in = 6'h3F;
  logic        look = 1'b0;
  logic [11:0] src_pair_run;
  logic [2:0]  cpu_pair_run;
  logic [3:0]  spread_adjust;
  logic [2:0]  freq_select;
  logic        pci_run;
  logic        pci_free_run;
  logic        panel;
  logic        spread;
  logic        fixed;
  logic        dbg;
  logic        pd;
  logic        hiz;
  logic        rdiv;
  logic [31:0] obs;
  note_t       notes[$];
  note_t       cur;
  int          bad_count = 0;
  int          n_tests = 0;
  int          seed = 67468;
  int          k;
  int          p;
  logic [7:0]  r;
  logic [31:0] cfg_t[5] = '{32'h00800800, 32'h00800200, 32'h08000040,
                            32'h80000020, 32'h80000010};
  logic [5:0]  en_t[5] = '{6'h01, 6'h02, 6'h0C, 6'h10, 6'h20};

  always #20 pclk = ~pclk;

  clkmux_if link();
  clock_request_host u_clock_request_host (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .request_n_in(request_n_in), .link(link));
  clock_request_pin_mux u_clock_request_pin_mux (.pclk(pclk),
    .presetn(presetn), .link(link), .src_pair_run(src_pair_run),
    .cpu_pair_run(cpu_pair_run), .pci_run(pci_run),
    .pci_free_run(pci_free_run), .panel_100m_clock(panel),
    .spread_27m_clock(spread), .fixed_27m_clock(fixed),
    .debug_pair_select(dbg), .spread_adjust(spread_adjust),
    .freq_select(freq_select), .powered_down(pd), .outputs_hiz(hiz),
    .outputs_ref_div(rdiv));
  clkmux_sva u_clkmux_sva (.pclk(pclk), .presetn(presetn),
    .cfg_we(link.cfg_we), .cfg_addr(link.cfg_addr),
    .cfg_wdata(link.cfg_wdata), .cfg_rdata(link.cfg_rdata),
    .peri_stop_n(link.peri_stop_n), .mgmt_mode(link.mgmt_mode),
    .request_pin_enable(link.request_pin_enable));

  assign obs = {1'b0, src_pair_run, cpu_pair_run, pci_run, pci_free_run,
    panel, spread, fixed, dbg, spread_adjust, freq_select, pd, hiz, rdiv};

  task automatic wrap_up();
    if (bad_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp_bus(input note_t n, input logic [32:0] got);
    n_tests++;
    if ((got & n.m) !== n.e)
    begin
      bad_count++;
      $display("wrong value apb exp %h got %h", n.e, got & n.m);
    end
  endtask

  task automatic cmp_pin(input note_t n, input logic [31:0] got);
    n_tests++;
    if ((got & n.m[31:0]) !== n.e[31:0])
    begin
      bad_count++;
      $display("wrong value pins exp %h got %h", n.e[31:0], got & n.m);
    end
  endtask

  // results are taken only at the edge that completes them
  always @(posedge pclk)
  begin
    if (look || (psel && penable && pready === 1'b1 && !pwrite))
    begin
      cur = notes.pop_front();
      if (cur.bus)
        cmp_bus(cur, {pslverr, prdata});
      else
        cmp_pin(cur, obs);
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 16);
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 16)
    begin
      bad_count++;
      wrap_up();
    end
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e, m);
    notes.push_back('{1'b1, e, m});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic pin(input logic [31:0] m, e);
    notes.push_back('{1'b0, {1'b0, e}, {1'b0, m}});
    look <= 1'b1;
    @(posedge pclk);
    look <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic cfg_wr(input logic [7:0] a, v);
    apb(1'b1, clkmux_pkg::APB_WDATA, {24'h0, v});
    apb(1'b1, clkmux_pkg::APB_CMD, {23'h0, 1'b1, a});
    repeat (2) @(posedge pclk);
  endtask

  task automatic cfg_rd(input logic [7:0] a, e);
    apb(1'b1, clkmux_pkg::APB_CMD, {23'h0, 1'b0, a});
    repeat (2) @(posedge pclk);
    rd(clkmux_pkg::APB_RDATA, {25'h0, e}, 33'h1000000FF);
  endtask

  task automatic ctl(input logic [7:0] v);
    apb(1'b1, clkmux_pkg::APB_CTRL, {24'h0, v});
    repeat (3) @(posedge pclk);
  endtask

  task automatic set4(input logic [31:0] b);
    cfg_wr(clkmux_pkg::PAIR_DIS_OFFSET, b[31:24]);
    cfg_wr(clkmux_pkg::PAIR3_DIS_OFFSET, b[23:16]);
    cfg_wr(clkmux_pkg::SEL_A_OFFSET, b[15:8]);
    cfg_wr(clkmux_pkg::SEL_B_OFFSET, b[7:0]);
  endtask

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    pin(32'h00002000, 32'h00002000);
    rd(8'h14, 33'h100000000, 33'h100000000);
    cfg_rd(clkmux_pkg::SEL_A_OFFSET, 8'h00);
    cfg_rd(clkmux_pkg::SEL_B_OFFSET, 8'h00);
    for (k = 0; k < 2; k++)
    begin
      ctl(k ? 8'h46 : 8'h86);
      pin(32'h4, 32'h4);
      ctl(k ? 8'h47 : 8'h87);
      pin(32'h08043C04, k ? 32'h08001800 : 32'h00042400);
    end
    // strap pins change after sampling and must be ignored
    ctl(8'h87);
    pin(32'h3C00, 32'h1800);
    r = 8'($random(seed));
    cfg_wr(clkmux_pkg::SPREAD_OFFSET, r);
    pin(32'h3C0, {22'h0, r[4:1], 6'h0});
    cfg_wr(clkmux_pkg::SEL_A_OFFSET, r);
    cfg_rd(clkmux_pkg::SEL_A_OFFSET, r);
    cfg_wr(clkmux_pkg::SEL_B_OFFSET, ~r);
    cfg_rd(clkmux_pkg::SEL_B_OFFSET, ~r);
    for (k = 0; k < 5; k++)
    begin
      r = 8'($random(seed));
      // without the pair disabled the pin stays a clock output
      set4(cfg_t[k] & 32'h0000FFFF);
      rd(clkmux_pkg::APB_STATUS, 33'h0, 33'h3F0);
      set4(cfg_t[k] | (k < 2 ? {16'h0, 5'h0, r[0], 1'b0, r[0], 8'h0} &
        (k ? 32'h100 : 32'h400) : 32'h0));
      rd(clkmux_pkg::APB_STATUS, {23'h0, en_t[k], 4'h0}, 33'h3F0);
      p = k == 0 ? (r[0] ? 2 : 0) : k == 1 ? (r[0] ? 4 : 1) :
        k == 2 ? 8 : k == 3 ? 10 : 3;
      request_n_in <= 6'h3F;
      repeat (3) @(posedge pclk);
      if (p >= 0)
        pin(32'h1 << (19 + p), 32'h0);
      request_n_in <= 6'h00;
      repeat (3) @(posedge pclk);
      if (p >= 0)
        pin(32'h1 << (19 + p), 32'h1 << (19 + p));
      request_n_in <= 6'h3F;
    end
    set4(32'h0);
    ctl(8'h05);
    pin(32'h00010000, 32'h0);
    ctl(8'h03);
    pin(32'h0080C000, 32'h00004000);
    ctl(8'h0F);
    ctl(8'h0E);
    r = 8'($random(seed));
    apb(1'b1, clkmux_pkg::APB_STATUS, {29'h0, r[2:0]});
    repeat (40) @(posedge pclk);
    rd(clkmux_pkg::APB_STATUS, 33'h0, 33'h8);
    pin(32'h00020000, 32'h00020000);
    ctl(8'h0F);
    pin(32'h38, {26'h0, r[2:0], 3'h0});
    ctl(8'h17);
    pin(32'h3, 32'h2);
    ctl(8'h37);
    pin(32'h3, 32'h1);
    wrap_up();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    wrap_up();
  end
endmodule

//--- verilog/clkmux_if.sv
// interface between the clock device and the chipset side
`timescale 1ns/1ns
interface clkmux_if;
  logic       cfg_we;
  logic [7:0] cfg_addr;
  logic [7:0] cfg_wdata;
  logic [7:0] cfg_rdata;
  logic       power_good_powerdown_n;
  logic       cpu_stop_n;
  logic       peri_stop_n;
  logic       mgmt_mode;
  logic       test_mode;
  logic       test_select;
  logic       sel_27_strap;
  logic       debug_port_clock_strap;
  logic [5:0] clock_request_n;
  logic [5:0] request_pin_enable;
  modport device
  (
    input  cfg_we, cfg_addr, cfg_wdata, power_good_powerdown_n,
    input  cpu_stop_n, peri_stop_n, mgmt_mode, test_mode, test_select,
    input  sel_27_strap, debug_port_clock_strap, clock_request_n,
    output cfg_rdata, request_pin_enable
  );
  modport host
  (
    output cfg_we, cfg_addr, cfg_wdata, power_good_powerdown_n,
    output cpu_stop_n, peri_stop_n, mgmt_mode, test_mode, test_select,
    output sel_27_strap, debug_port_clock_strap, clock_request_n,
    input  cfg_rdata, request_pin_enable
  );
endinterface

//--- verilog/clkmux_pkg.sv
// shared constants for the clock request pin mux and its host
package clkmux_pkg;
  localparam logic [7:0] SEL_A_OFFSET     = 8'h05;
  localparam logic [7:0] SEL_B_OFFSET     = 8'h06;
  localparam logic [7:0] PAIR_DIS_OFFSET  = 8'h03;
  localparam logic [7:0] PAIR3_DIS_OFFSET = 8'h04;
  localparam logic [7:0] SPREAD_OFFSET    = 8'h01;
  localparam logic [7:0] REG_RESET        = 8'h00;
  // field positions in request_pin_select_a
  localparam int REQ_C_EN_BIT  = 3;
  localparam int REQ_C_SEL_BIT = 2;
  localparam int REQ_D_EN_BIT  = 1;
  localparam int REQ_D_SEL_BIT = 0;
  // field positions in request_pin_select_b
  localparam int REQ_EF_EN_BIT = 6;
  localparam int REQ_G_EN_BIT  = 5;
  localparam int REQ_H_EN_BIT  = 4;
  // pair disable bits
  localparam int PAIR11_DIS_BIT = 7;
  localparam int PAIR7_DIS_BIT  = 3;
  localparam int PAIR3_DIS_BIT  = 7;
  localparam int SPREAD_LSB     = 1;
  localparam int SPREAD_MSB     = 4;
  localparam int PAIRS          = 12;
  localparam int FS_BITS        = 3;
  // host apb register offsets
  localparam logic [7:0] APB_CMD    = 8'h00;
  localparam logic [7:0] APB_WDATA  = 8'h04;
  localparam logic [7:0] APB_STATUS = 8'h08;
  localparam logic [7:0] APB_CTRL   = 8'h0C;
  localparam logic [7:0] APB_RDATA  = 8'h10;
  // ctrl bits
  localparam int CTRL_PWRGD_BIT = 0;
  localparam int CTRL_CSTOP_BIT = 1;
  localparam int CTRL_PSTOP_BIT = 2;
  localparam int CTRL_MGMT_BIT  = 3;
  localparam int CTRL_TEST_BIT  = 4;
  localparam int CTRL_TSEL_BIT  = 5;
  localparam int CTRL_S27_BIT   = 6;
  localparam int CTRL_DBG_BIT   = 7;
  localparam int SHIFT_HALF     = 2;
  typedef enum logic [1:0]
  {
    SH_IDLE = 2'b00,
    SH_LOW  = 2'b01,
    SH_HIGH = 2'b10
  } shift_state_t;
endpackage

//--- verilog/clock_request_host.sv
// chipset end: apb registers driving the clock control sideband
`timescale 1ns/1ns
module clock_request_host
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [5:0]  request_n_in,
  clkmux_if.host           link
);
  logic [7:0] ctrl_q, wdata_q, rdata_q, cmd_addr_q;
  logic       busy_q, we_q;
  logic [2:0] fs_q;
  logic [1:0] bit_q;
  logic [3:0] cnt_q;
  clkmux_pkg::shift_state_t st_q;
  logic       wr, hit;

  assign pready  = 1'b1;
  assign wr      = psel & penable & pwrite;
  assign hit     = paddr == clkmux_pkg::APB_CMD
                 | paddr == clkmux_pkg::APB_WDATA
                 | paddr == clkmux_pkg::APB_STATUS
                 | paddr == clkmux_pkg::APB_CTRL
                 | paddr == clkmux_pkg::APB_RDATA;
  assign pslverr = psel & penable & ~hit;

  // cmd: bit 8 write, bits 7..0 config byte; status bits 2..0 shift fs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q     <= 8'h00;
      wdata_q    <= 8'h00;
      cmd_addr_q <= 8'h00;
      we_q       <= 1'b0;
      fs_q       <= 3'h0;
      rdata_q    <= 8'h00;
    end
    else
    begin
      we_q    <= 1'b0;
      rdata_q <= link.cfg_rdata;
      if (wr && paddr == clkmux_pkg::APB_CMD)
      begin
        cmd_addr_q <= pwdata[7:0];
        we_q       <= pwdata[8]; // software orders writes
      end
      else if (wr && paddr == clkmux_pkg::APB_WDATA)
        wdata_q <= pwdata[7:0];
      else if (wr && paddr == clkmux_pkg::APB_CTRL)
        ctrl_q <= pwdata[7:0];
      else if (wr && paddr == clkmux_pkg::APB_STATUS)
        fs_q <= pwdata[2:0];
    end
  end

  // serial load of select bits, c first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q   <= clkmux_pkg::SH_IDLE;
      bit_q  <= 2'h0;
      cnt_q  <= 4'h0;
      busy_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        clkmux_pkg::SH_IDLE:
        begin
          if (wr && paddr == clkmux_pkg::APB_STATUS)
          begin
            st_q   <= clkmux_pkg::SH_LOW;
            bit_q  <= 2'h0;
            cnt_q  <= 4'h0;
            busy_q <= 1'b1;
          end
        end
        clkmux_pkg::SH_LOW:
        begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'(clkmux_pkg::SHIFT_HALF))
          begin
            cnt_q <= 4'h0;
            st_q  <= clkmux_pkg::SH_HIGH;
          end
        end
        clkmux_pkg::SH_HIGH:
        begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == 4'(clkmux_pkg::SHIFT_HALF))
          begin
            cnt_q <= 4'h0;
            bit_q <= bit_q + 2'h1;
            if (bit_q == 2'h2)
            begin
              st_q   <= clkmux_pkg::SH_IDLE;
              busy_q <= 1'b0;
            end
            else
              st_q <= clkmux_pkg::SH_LOW;
          end
        end
        default:
          st_q <= clkmux_pkg::SH_IDLE;
      endcase
    end
  end

  always_comb
  begin
    if (paddr == clkmux_pkg::APB_CTRL)
      prdata = {24'h0, ctrl_q};
    else if (paddr == clkmux_pkg::APB_WDATA)
      prdata = {24'h0, wdata_q};
    else if (paddr == clkmux_pkg::APB_STATUS)
      prdata = {22'h0, link.request_pin_enable, busy_q, 3'h0};
    else if (paddr == clkmux_pkg::APB_RDATA)
      prdata = {24'h0, rdata_q};
    else if (paddr == clkmux_pkg::APB_CMD)
      prdata = {24'h0, cmd_addr_q};
    else
      prdata = 32'h0;
  end

  assign link.cfg_we    = we_q;
  assign link.cfg_addr  = cmd_addr_q;
  assign link.cfg_wdata = wdata_q;
  assign link.power_good_powerdown_n = ctrl_q[clkmux_pkg::CTRL_PWRGD_BIT];
  assign link.cpu_stop_n = busy_q ? fs_q[2 - bit_q]
                                  : ctrl_q[clkmux_pkg::CTRL_CSTOP_BIT];
  assign link.peri_stop_n = busy_q ? (st_q == clkmux_pkg::SH_HIGH)
                                   : ctrl_q[clkmux_pkg::CTRL_PSTOP_BIT];
  assign link.mgmt_mode   = ctrl_q[clkmux_pkg::CTRL_MGMT_BIT];
  assign link.test_mode   = ctrl_q[clkmux_pkg::CTRL_TEST_BIT];
  assign link.test_select = ctrl_q[clkmux_pkg::CTRL_TSEL_BIT];
  assign link.sel_27_strap = ctrl_q[clkmux_pkg::CTRL_S27_BIT];
  assign link.debug_port_clock_strap = ctrl_q[clkmux_pkg::CTRL_DBG_BIT];
  assign link.clock_request_n = request_n_in;
endmodule

//--- verilog/clock_request_pin_mux.sv
// device end: strap latches, request pins and output gating
// Functional notes
// - 27MHz strap picks panel or fixed 27MHz
// - strap 0: byte1 bits 4..1 adjust pair
// - strap 1: spread 27MHz, adjustable spread
// - host disables pair 3, 7 or 11 before request use
// - byte5 bit3 makes pair3 true request C
// - byte5 bit2 routes C to pair 0/2
// - byte5 bit1 makes pair3 complement request D
// - byte5 bit0 routes D to pair 1/4
// - byte6 bit5 request G gates pair 10
// - byte6 bit4 request H gates pair 3
// - byte6 bit6 requests E,F gate pair 8
// - debug strap picks pair 8 or debug clock
// - cpu stop halts non-free cpu clocks
// - peripheral stop halts non-free pci/src clocks
// - management mode shifts in three select bits
// - peripheral stop pin clocks select bits
// - cpu pair 1 runs in management mode
// - power good samples straps, modes
// - test select picks high-z or divided ref
// - 27MHz strap sampled once, pin reverts
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
module clock_request_pin_mux
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  clkmux_if.device         link,
  output logic [11:0]      src_pair_run,
  output logic [2:0]       cpu_pair_run,
  output logic             pci_run,
  output logic             pci_free_run,
  output logic             panel_100m_clock,
  output logic             spread_27m_clock,
  output logic             fixed_27m_clock,
  output logic             debug_pair_select,
  output logic [3:0]       spread_adjust,
  output logic [2:0]       freq_select,
  output logic             powered_down,
  output logic             outputs_hiz,
  output logic             outputs_ref_div
);
  logic [7:0] spread_q, dis_q, dis3_q, sel_a_q, sel_b_q;
  logic       s27_q, dbg_q, pg_q, mgmt_q, pstop_q;
  logic [2:0] fs_q, shift_q;
  logic [5:0] en;
  logic [5:0] req;

  // configuration byte writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      spread_q <= clkmux_pkg::REG_RESET;
      dis_q    <= clkmux_pkg::REG_RESET;
      dis3_q   <= clkmux_pkg::REG_RESET;
      sel_a_q  <= clkmux_pkg::REG_RESET;
      sel_b_q  <= clkmux_pkg::REG_RESET;
    end
    else if (link.cfg_we)
    begin
      if (link.cfg_addr == clkmux_pkg::SPREAD_OFFSET)
        spread_q <= link.cfg_wdata;
      else if (link.cfg_addr == clkmux_pkg::PAIR_DIS_OFFSET)
        dis_q <= link.cfg_wdata;
      else if (link.cfg_addr == clkmux_pkg::PAIR3_DIS_OFFSET)
        dis3_q <= link.cfg_wdata;
      else if (link.cfg_addr == clkmux_pkg::SEL_A_OFFSET)
        sel_a_q <= link.cfg_wdata;
      else if (link.cfg_addr == clkmux_pkg::SEL_B_OFFSET)
        sel_b_q <= link.cfg_wdata;
    end
  end

  always_comb
  begin
    if (link.cfg_addr == clkmux_pkg::SPREAD_OFFSET)
      link.cfg_rdata = spread_q;
    else if (link.cfg_addr == clkmux_pkg::PAIR_DIS_OFFSET)
      link.cfg_rdata = dis_q;
    else if (link.cfg_addr == clkmux_pkg::PAIR3_DIS_OFFSET)
      link.cfg_rdata = dis3_q;
    else if (link.cfg_addr == clkmux_pkg::SEL_A_OFFSET)
      link.cfg_rdata = sel_a_q;
    else if (link.cfg_addr == clkmux_pkg::SEL_B_OFFSET)
      link.cfg_rdata = sel_b_q;
    else
      link.cfg_rdata = 8'h00;
  end

  // straps caught on the rising edge of power good, not at reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pg_q  <= 1'b0;
      s27_q <= 1'b0;
      dbg_q <= 1'b0;
    end
    else
    begin
      pg_q <= link.power_good_powerdown_n;
      if (link.power_good_powerdown_n && !pg_q)
      begin
        s27_q <= link.sel_27_strap;
        dbg_q <= link.debug_port_clock_strap;
      end
    end
  end

  // management mode: select bits shift on peripheral stop rising edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mgmt_q  <= 1'b0;
      pstop_q <= 1'b1;
      shift_q <= 3'h0;
      fs_q    <= 3'h0;
    end
    else
    begin
      pstop_q <= link.peri_stop_n;
      if (link.power_good_powerdown_n != pg_q)
        mgmt_q <= link.mgmt_mode & ~link.power_good_powerdown_n;
      if (mgmt_q && link.peri_stop_n && !pstop_q)
        shift_q <= {shift_q[1:0], link.cpu_stop_n};
      if (mgmt_q && link.power_good_powerdown_n && !pg_q)
        fs_q <= shift_q;
    end
  end

  assign en[0] = sel_a_q[clkmux_pkg::REQ_C_EN_BIT]
                 & dis3_q[clkmux_pkg::PAIR3_DIS_BIT];
  assign en[1] = sel_a_q[clkmux_pkg::REQ_D_EN_BIT]
                 & dis3_q[clkmux_pkg::PAIR3_DIS_BIT];
  assign en[2] = sel_b_q[clkmux_pkg::REQ_EF_EN_BIT]
                 & dis_q[clkmux_pkg::PAIR7_DIS_BIT];
  assign en[3] = en[2];
  assign en[4] = sel_b_q[clkmux_pkg::REQ_G_EN_BIT]
                 & dis_q[clkmux_pkg::PAIR11_DIS_BIT];
  assign en[5] = sel_b_q[clkmux_pkg::REQ_H_EN_BIT]
                 & dis_q[clkmux_pkg::PAIR11_DIS_BIT];
  assign link.request_pin_enable = en;
  // a disabled request pin reads as asserted so it never gates
  assign req = ~link.clock_request_n & en | ~en;

  logic pstop_act, cstop_act;
  assign pstop_act = ~link.peri_stop_n & ~mgmt_q;
  assign cstop_act = ~link.cpu_stop_n & ~mgmt_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      src_pair_run <= 12'h000;
      cpu_pair_run <= 3'h0;
      pci_run      <= 1'b0;
      pci_free_run <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < clkmux_pkg::PAIRS; i++)
        src_pair_run[i] <= link.power_good_powerdown_n & ~pstop_act;
      // gate targets by the request pins
      // req reads high when c is off, so no enable term is needed here
      src_pair_run[0] <= link.power_good_powerdown_n & ~pstop_act
        & (sel_a_q[clkmux_pkg::REQ_C_SEL_BIT] | req[0]);
      src_pair_run[2] <= link.power_good_powerdown_n & ~pstop_act
        & (!sel_a_q[clkmux_pkg::REQ_C_SEL_BIT] | req[0]);
      src_pair_run[1] <= link.power_good_powerdown_n & ~pstop_act
        & (sel_a_q[clkmux_pkg::REQ_D_SEL_BIT] | req[1]);
      src_pair_run[4] <= link.power_good_powerdown_n & ~pstop_act
        & (!sel_a_q[clkmux_pkg::REQ_D_SEL_BIT] | req[1]);
      src_pair_run[3] <= link.power_good_powerdown_n & ~pstop_act
        & ~dis3_q[clkmux_pkg::PAIR3_DIS_BIT] & req[5];
      src_pair_run[7] <= link.power_good_powerdown_n & ~pstop_act
        & ~dis_q[clkmux_pkg::PAIR7_DIS_BIT];
      src_pair_run[8] <= link.power_good_powerdown_n & ~pstop_act
        & ~dbg_q & req[2] & req[3];
      src_pair_run[10] <= link.power_good_powerdown_n & ~pstop_act
        & req[4];
      src_pair_run[11] <= link.power_good_powerdown_n & ~pstop_act
        & ~dis_q[clkmux_pkg::PAIR11_DIS_BIT];
      cpu_pair_run[0] <= link.power_good_powerdown_n & ~cstop_act
        & ~mgmt_q;
      cpu_pair_run[1] <= link.power_good_powerdown_n | mgmt_q;
      cpu_pair_run[2] <= link.power_good_powerdown_n & ~cstop_act
        & ~mgmt_q & dbg_q;
      pci_run      <= link.power_good_powerdown_n & ~pstop_act;
      pci_free_run <= link.power_good_powerdown_n;
    end
  end

  assign panel_100m_clock  = ~s27_q;
  assign fixed_27m_clock   = s27_q;
  assign spread_27m_clock  = s27_q;
  assign spread_adjust     = spread_q[clkmux_pkg::SPREAD_MSB:
                                      clkmux_pkg::SPREAD_LSB];
  assign debug_pair_select = dbg_q;
  assign freq_select       = fs_q;
  assign powered_down      = ~link.power_good_powerdown_n & ~mgmt_q;
  assign outputs_hiz       = link.test_mode & ~link.test_select;
  assign outputs_ref_div   = link.test_mode & link.test_select;
endmodule
